// file: common/prc_pkg.sv
// constants and carrier types shared by the power, reset and clock register bank
package prc_pkg;
  // register indices as printed; byte address is four times the index, cut to the address width
  localparam logic [31:0] IDX_STATUS   = 32'h5000002A;
  localparam logic [31:0] IDX_CONV1    = 32'h05000080;
  localparam logic [31:0] IDX_CONV2    = 32'h05000082;
  localparam logic [31:0] IDX_PIN      = 32'h50000040;
  localparam logic [31:0] IDX_HOLD     = 32'h50000042;
  localparam logic [31:0] IDX_CONV3    = 32'h50000084;
  localparam logic [31:0] IDX_PCDIV    = 32'h50001C40;
  localparam logic [31:0] IDX_PCFRAC   = 32'h50001C42;
  localparam logic [31:0] IDX_PDDIV    = 32'h50001C44;
  localparam logic [31:0] IDX_RCDIV    = 32'h50001C46;
  localparam logic [31:0] IDX_CLKSRC   = 32'h50000012;
  // writable bit masks; everything else reads zero
  localparam logic [15:0] MASK_CONV1   = 16'hFFEE;
  localparam logic [15:0] MASK_CONV2   = 16'hFFFF;
  localparam logic [15:0] MASK_PIN     = 16'h00BF;
  localparam logic [15:0] MASK_HOLD    = 16'h007F;
  localparam logic [15:0] MASK_CONV3   = 16'h001F;
  localparam logic [15:0] MASK_PCDIV   = 16'h1FFF;
  localparam logic [15:0] MASK_PCFRAC  = 16'hFFFF;
  localparam logic [15:0] MASK_PDDIV   = 16'h03FF;
  localparam logic [15:0] MASK_RCDIV   = 16'h01FF;
  localparam logic [15:0] MASK_CLKSRC  = 16'h0008;
  // reset values
  localparam logic [15:0] RST_CONV1    = 16'h000C;
  localparam logic [15:0] RST_CONV2    = 16'h8C20;
  localparam logic [15:0] RST_PIN      = 16'h0000;
  localparam logic [15:0] RST_HOLD     = 16'h0018;
  localparam logic [15:0] RST_CONV3    = 16'h0015;
  localparam logic [15:0] RST_ZERO     = 16'h0000;
  // field positions
  localparam int POS_PIN_POL   = 7;
  localparam int POS_PC_EN     = 12;
  localparam int POS_PD_ROLE   = 9;
  localparam int POS_PD_EN     = 8;
  localparam int POS_RC_EN     = 8;
  localparam int POS_SRC_SEL   = 3;
  localparam int POS_BUCK_EN   = 0;
  localparam int POS_BOOST_MSB = 11;
  // timing
  localparam int SLOW_PERIODS_PER_STEP = 4096;
  localparam logic [2:0] THRESH_ALWAYS_OK = 3'h7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int PIN_COUNT = 32;

  typedef struct packed {
    logic step_up_active;
    logic reference_good;
    logic boost_battery_good;
    logic adc_regulator_good;
    logic core_regulator_good;
    logic converter_output_good;
    logic low_rail_above_threshold;
    logic low_rail_present;
  } analog_status_s;

  typedef struct packed {
    logic [1:0] sense_tune;
    logic [1:0] output_switch_drive;
    logic [1:0] battery_switch_drive;
    logic [1:0] ground_switch_drive;
    logic [2:0] test_mode;
    logic [2:0] low_rail_threshold;
    logic [3:0] output_level_select;
    logic [2:0] boosted_level_select;
    logic [1:0] comparator_min_on_time;
    logic [3:0] switch_current_limit;
    logic [2:0] auto_calibration;
    logic [1:0] idle_timeout;
    logic [1:0] idle_clock_select;
    logic       idle_use_slow_clock;
    logic       boost_permitted;
    logic       buck_start;
  } converter_ctrl_s;
endpackage

// file: hw/prc_reg_bank.sv
// register bank, reset pin timer and audio clock dividers of the power/clock unit
`timescale 1ns/1ps
// Functional notes
// R1: analogue status word is read-only; bits 9,7,6,5,4,2,1,0 report supplies.
// R2: pin register bit 7 sets general pin polarity; reset pad always active high.
// R3: six-bit selector, zero disables; codes 1.. map port pins in order.
// R4: reset delay is hold value times 4096 periods of the selected slow clock; resets 0x18.
// R5: software writes pulse-code divider before or with its enable bit 12.
// R6: fraction: leftmost one gives denominator, set bits give numerator and spread.
// R7: pulse-density bit 9 picks role: 0 slave receives clock, 1 master drives.
// R8: software writes pulse-density divider before or with its enable bit 8.
// R9: software writes rate-converter divider before or with its enable bit 8.
// R10: switch drive fields: 00 full, 01 two-thirds, 10 one-third, 11 off.
// R11: boost disabled when low rail under threshold field; 111 always fine.
// R12: output level field N sets 1.2 V plus N times 25 mV; resets 0x8.
// R13: boosted level field; top bit forced on while memory regulator enabled.
// R14: software sets min on-time 0x2 buck, 0x1 boost; field resets zero.
// R15: calibration field zero disables calibration; 0x1 buck, 0x6 boost advised.
// R16: current limit field N gives about N times 10 mA; resets 0x4.
// R17: idle trigger clock per select; slow clock used when no fast oscillator.
// R18: buck-enable bit starts buck on activation while low rail grounded.
// R19: tune field compensates sensing; mode field stays 000 in normal use.
// R20: slow clock source bit: 0 RC oscillator, 1 crystal oscillator.
// R21: timer counts slow periods while pin active, fires at end, restarts on release.
// R22: reserved bits read zero and ignore writes.
module prc_reg_bank #(
  parameter int PERIODS_PER_STEP = prc_pkg::SLOW_PERIODS_PER_STEP
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic [31:0]              s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [31:0]              s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire prc_pkg::analog_status_s  analog_status,
  input  wire logic [31:0]              port_pins,
  input  wire logic                     reset_pad,
  input  wire logic                     slow_rc_clock,
  input  wire logic                     slow_xtal_clock,
  input  wire logic                     memory_regulator_on,
  input  wire logic                     fast_oscillator_running,
  input  wire logic                     device_active,
  output logic                          power_on_reset_event,
  output logic                          pulse_code_clock,
  output logic                          pulse_density_clock,
  output logic                          pulse_density_clock_oe,
  output logic                          rate_converter_clock,
  output prc_pkg::converter_ctrl_s      converter_ctrl
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old & ~lanes) | (wd[15:0] & lanes);
  endfunction

  // a period is div cycles, plus one when the fraction asks for it; zero acts as one
  function automatic logic div_done(input logic [12:0] cnt, input logic [11:0] div, input logic extra);
    logic [12:0] per;
    per = (div == 12'h000) ? 13'h0001 : {1'b0, div};
    div_done = (cnt >= per - 13'h0001 + {12'h000, extra});
  endfunction

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int SYNC_W = 8 + 32 + 6;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              slow_prev_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {analog_status, port_pins, reset_pad, slow_rc_clock, slow_xtal_clock,
                  memory_regulator_on, fast_oscillator_running, device_active};
      sync2_q <= sync1_q;
    end
  end

  prc_pkg::analog_status_s st;
  wire logic [31:0] pins_s     = sync2_q[37:6];
  wire logic        pad_s      = sync2_q[5];
  wire logic        rc_s       = sync2_q[4];
  wire logic        xtal_s     = sync2_q[3];
  wire logic        memreg_s   = sync2_q[2];
  wire logic        fastosc_s  = sync2_q[1];
  wire logic        active_s   = sync2_q[0];
  assign st = prc_pkg::analog_status_s'(sync2_q[45:38]);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] conv1_q, conv2_q, conv3_q, pin_q, hold_q;
  logic [15:0] pcdiv_q, pcfrac_q, pddiv_q, rcdiv_q, clksrc_q;

  logic aw_rdy_q, b_valid_q, ar_rdy_q, r_valid_q;
  logic [1:0] b_resp_q, r_resp_q;
  logic [31:0] r_data_q;

  wire logic wr_fire = s_axi_awvalid & s_axi_wvalid & aw_rdy_q;
  wire logic wr_arm  = s_axi_awvalid & s_axi_wvalid & ~aw_rdy_q & ~b_valid_q;
  wire logic rd_fire = s_axi_arvalid & ar_rdy_q;
  wire logic rd_arm  = s_axi_arvalid & ~ar_rdy_q & ~r_valid_q;

  wire logic [29:0] wi = s_axi_awaddr[31:2];
  wire logic [29:0] ri = s_axi_araddr[31:2];
  wire logic w_conv1  = wi == prc_pkg::IDX_CONV1[29:0];
  wire logic w_conv2  = wi == prc_pkg::IDX_CONV2[29:0];
  wire logic w_conv3  = wi == prc_pkg::IDX_CONV3[29:0];
  wire logic w_pin    = wi == prc_pkg::IDX_PIN[29:0];
  wire logic w_hold   = wi == prc_pkg::IDX_HOLD[29:0];
  wire logic w_pcdiv  = wi == prc_pkg::IDX_PCDIV[29:0];
  wire logic w_pcfrac = wi == prc_pkg::IDX_PCFRAC[29:0];
  wire logic w_pddiv  = wi == prc_pkg::IDX_PDDIV[29:0];
  wire logic w_rcdiv  = wi == prc_pkg::IDX_RCDIV[29:0];
  wire logic w_clksrc = wi == prc_pkg::IDX_CLKSRC[29:0];
  wire logic w_stat   = wi == prc_pkg::IDX_STATUS[29:0];
  wire logic w_hit    = w_conv1 | w_conv2 | w_conv3 | w_pin | w_hold | w_pcdiv | w_pcfrac |
                        w_pddiv | w_rcdiv | w_clksrc | w_stat;

  // status word, read-only; writes to it are answered but change nothing
  wire logic [15:0] status_word = {6'h00, st.step_up_active, 1'b0, st.reference_good,   // R1
                                   st.boost_battery_good, st.adc_regulator_good,
                                   st.core_regulator_good, 1'b0, st.converter_output_good,
                                   st.low_rail_above_threshold, st.low_rail_present};

  logic [15:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 16'h0000;
    case (ri)
      prc_pkg::IDX_STATUS[29:0]: rd_word = status_word;
      prc_pkg::IDX_CONV1[29:0]:  rd_word = conv1_q;
      prc_pkg::IDX_CONV2[29:0]:  rd_word = conv2_q;
      prc_pkg::IDX_CONV3[29:0]:  rd_word = conv3_q;
      prc_pkg::IDX_PIN[29:0]:    rd_word = pin_q;
      prc_pkg::IDX_HOLD[29:0]:   rd_word = hold_q;
      prc_pkg::IDX_PCDIV[29:0]:  rd_word = pcdiv_q;
      prc_pkg::IDX_PCFRAC[29:0]: rd_word = pcfrac_q;
      prc_pkg::IDX_PDDIV[29:0]:  rd_word = pddiv_q;
      prc_pkg::IDX_RCDIV[29:0]:  rd_word = rcdiv_q;
      prc_pkg::IDX_CLKSRC[29:0]: rd_word = clksrc_q;
      default:                   rd_hit  = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // bus handshake: ready rises one cycle after both channels show valid
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_rdy_q  <= 1'b0;
      b_valid_q <= 1'b0;
      b_resp_q  <= prc_pkg::RESP_OKAY;
      ar_rdy_q  <= 1'b0;
      r_valid_q <= 1'b0;
      r_resp_q  <= prc_pkg::RESP_OKAY;
      r_data_q  <= 32'h00000000;
    end else begin
      aw_rdy_q <= wr_arm;
      if (wr_fire) begin
        b_valid_q <= 1'b1;
        b_resp_q  <= w_hit ? prc_pkg::RESP_OKAY : prc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        b_valid_q <= 1'b0;
      end
      ar_rdy_q <= rd_arm;
      if (rd_fire) begin
        r_valid_q <= 1'b1;
        r_data_q  <= {16'h0000, rd_word};                                            // R22
        r_resp_q  <= rd_hit ? prc_pkg::RESP_OKAY : prc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        r_valid_q <= 1'b0;
      end
    end
  end

  // masks keep reserved bits at zero whatever is written
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      conv1_q  <= prc_pkg::RST_CONV1;
      conv2_q  <= prc_pkg::RST_CONV2;
      conv3_q  <= prc_pkg::RST_CONV3;
      pin_q    <= prc_pkg::RST_PIN;
      hold_q   <= prc_pkg::RST_HOLD;                                                 // R4
      pcdiv_q  <= prc_pkg::RST_ZERO;
      pcfrac_q <= prc_pkg::RST_ZERO;
      pddiv_q  <= prc_pkg::RST_ZERO;
      rcdiv_q  <= prc_pkg::RST_ZERO;
      clksrc_q <= prc_pkg::RST_ZERO;
    end else if (wr_fire) begin
      if (w_conv1)  conv1_q  <= merge(conv1_q, s_axi_wdata, s_axi_wstrb, prc_pkg::MASK_CONV1);    // R22
      if (w_conv2)  conv2_q  <= merge(conv2_q, s_axi_wdata, s_axi_wstrb, prc_pkg::MASK_CONV2);
      if (w_conv3)  conv3_q  <= merge(conv3_q, s_axi_wdata, s_axi_wstrb, prc_pkg::MASK_CONV3);
      if (w_pin)    pin_q    <= merge(pin_q, s_axi_wdata, s_axi_wstrb, prc_pkg::MASK_PIN);
      if (w_hold)   hold_q   <= merge(hold_q, s_axi_wdata, s_axi_wstrb, prc_pkg::MASK_HOLD);
      if (w_pcdiv)  pcdiv_q  <= merge(pcdiv_q, s_axi_wdata, s_axi_wstrb, prc_pkg::MASK_PCDIV);
      if (w_pcfrac) pcfrac_q <= merge(pcfrac_q, s_axi_wdata, s_axi_wstrb, prc_pkg::MASK_PCFRAC);
      if (w_pddiv)  pddiv_q  <= merge(pddiv_q, s_axi_wdata, s_axi_wstrb, prc_pkg::MASK_PDDIV);
      if (w_rcdiv)  rcdiv_q  <= merge(rcdiv_q, s_axi_wdata, s_axi_wstrb, prc_pkg::MASK_RCDIV);
      if (w_clksrc) clksrc_q <= merge(clksrc_q, s_axi_wdata, s_axi_wstrb, prc_pkg::MASK_CLKSRC);
    end
  end

  // ---------------------------------------------------------------
  // reset pin hold timer
  // ---------------------------------------------------------------
  logic [18:0] period_cnt_q;
  logic [6:0]  step_cnt_q;
  logic        por_q;

  wire logic [5:0] pin_sel  = pin_q[5:0];
  wire logic       pin_pol  = pin_q[prc_pkg::POS_PIN_POL];
  wire logic       sel_ok   = (pin_sel != 6'h00) && (pin_sel <= 6'(prc_pkg::PIN_COUNT));   // R3
  wire logic [4:0] pin_idx  = 5'(pin_sel - 6'h01);                                          // R3
  wire logic       gpio_act = sel_ok & ~(pins_s[pin_idx] ^ pin_pol);                        // R2
  wire logic       hold_act = gpio_act | pad_s;                                             // R2
  wire logic       slow_sel = clksrc_q[prc_pkg::POS_SRC_SEL] ? xtal_s : rc_s;               // R20
  wire logic       slow_edge = slow_sel & ~slow_prev_q;
  wire logic       step_end = period_cnt_q == 19'(PERIODS_PER_STEP - 1);
  wire logic       hold_done = step_cnt_q >= hold_q[6:0];                                   // R4

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slow_prev_q  <= 1'b0;
      period_cnt_q <= 19'h00000;
      step_cnt_q   <= 7'h00;
      por_q        <= 1'b0;
    end else begin
      slow_prev_q <= slow_sel;
      if (!hold_act) begin                                                                  // R21
        period_cnt_q <= 19'h00000;
        step_cnt_q   <= 7'h00;
        por_q        <= 1'b0;
      end else if (hold_done) begin
        por_q <= 1'b1;                                                                      // R21
      end else if (slow_edge) begin
        period_cnt_q <= step_end ? 19'h00000 : period_cnt_q + 19'h00001;                    // R4
        if (step_end) step_cnt_q <= step_cnt_q + 7'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // audio clock dividers
  // ---------------------------------------------------------------
  logic [12:0] pc_cnt_q, pd_cnt_q, rc_cnt_q;
  logic [3:0]  frac_idx_q;
  logic        pc_clk_q, pd_clk_q, pd_oe_q, rc_clk_q;

  logic [3:0] frac_top;
  always_comb begin
    frac_top = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (pcfrac_q[i]) frac_top = 4'(i);                                                    // R6
    end
  end
  // extra cycle where the pattern bit under the cursor is set
  wire logic frac_extra = pcfrac_q[frac_idx_q];                                             // R6

  wire logic pc_en = pcdiv_q[prc_pkg::POS_PC_EN];                                           // R5
  wire logic pd_en = pddiv_q[prc_pkg::POS_PD_EN];                                           // R8
  wire logic rc_en = rcdiv_q[prc_pkg::POS_RC_EN];                                           // R9
  wire logic pc_tick = div_done(pc_cnt_q, pcdiv_q[11:0], frac_extra);
  wire logic pd_tick = div_done(pd_cnt_q, {4'h0, pddiv_q[7:0]}, 1'b0);
  wire logic rc_tick = div_done(rc_cnt_q, {4'h0, rcdiv_q[7:0]}, 1'b0);
  wire logic pd_master = pddiv_q[prc_pkg::POS_PD_ROLE];                                     // R7

  // divider settings are read live, so a divider written after its enable
  // produces one odd period; software orders the writes to avoid it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pc_cnt_q   <= 13'h0000;
      pd_cnt_q   <= 13'h0000;
      rc_cnt_q   <= 13'h0000;
      frac_idx_q <= 4'h0;
      pc_clk_q   <= 1'b0;
      pd_clk_q   <= 1'b0;
      pd_oe_q    <= 1'b0;
      rc_clk_q   <= 1'b0;
    end else begin
      if (!pc_en) begin                                                                     // R5
        pc_cnt_q   <= 13'h0000;
        frac_idx_q <= frac_top;
        pc_clk_q   <= 1'b0;
      end else if (pc_tick) begin
        pc_cnt_q   <= 13'h0000;
        pc_clk_q   <= ~pc_clk_q;
        frac_idx_q <= (frac_idx_q == 4'h0) ? frac_top : frac_idx_q - 4'h1;                  // R6
      end else begin
        pc_cnt_q <= pc_cnt_q + 13'h0001;
      end
      if (!pd_en) begin                                                                     // R8
        pd_cnt_q <= 13'h0000;
        pd_clk_q <= 1'b0;
      end else if (pd_tick) begin
        pd_cnt_q <= 13'h0000;
        pd_clk_q <= ~pd_clk_q;
      end else begin
        pd_cnt_q <= pd_cnt_q + 13'h0001;
      end
      pd_oe_q <= pd_master & pd_en;                                                         // R7
      if (!rc_en) begin                                                                     // R9
        rc_cnt_q <= 13'h0000;
        rc_clk_q <= 1'b0;
      end else if (rc_tick) begin
        rc_cnt_q <= 13'h0000;
        rc_clk_q <= ~rc_clk_q;
      end else begin
        rc_cnt_q <= rc_cnt_q + 13'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // converter control outputs
  // ---------------------------------------------------------------
  prc_pkg::converter_ctrl_s conv_d, conv_q;
  always_comb begin
    conv_d.sense_tune             = conv1_q[15:14];                                         // R19
    conv_d.output_switch_drive    = conv1_q[13:12];                                         // R10
    conv_d.battery_switch_drive   = conv1_q[11:10];                                         // R10
    conv_d.ground_switch_drive    = conv1_q[9:8];                                           // R10
    conv_d.test_mode              = conv1_q[7:5];                                           // R19
    conv_d.low_rail_threshold     = conv1_q[3:1];                                           // R11
    conv_d.output_level_select    = conv2_q[15:12];                                         // R12
    conv_d.boosted_level_select   = {conv2_q[prc_pkg::POS_BOOST_MSB] | memreg_s, conv2_q[10:9]}; // R13
    conv_d.comparator_min_on_time = conv2_q[8:7];                                           // R14
    conv_d.switch_current_limit   = conv2_q[6:3];                                           // R16
    conv_d.auto_calibration       = conv2_q[2:0];                                           // R15
    conv_d.idle_timeout           = conv3_q[4:3];
    conv_d.idle_clock_select      = conv3_q[2:1];                                           // R17
    conv_d.idle_use_slow_clock    = ~fastosc_s;                                             // R17
    conv_d.boost_permitted        = st.low_rail_above_threshold |
                                    (conv1_q[3:1] == prc_pkg::THRESH_ALWAYS_OK);            // R11
    conv_d.buck_start             = conv3_q[prc_pkg::POS_BUCK_EN] & active_s &
                                    ~st.low_rail_present;                                   // R18
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      conv_q <= '0;
    end else begin
      conv_q <= conv_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready          = aw_rdy_q;
  assign s_axi_wready           = aw_rdy_q;
  assign s_axi_bvalid           = b_valid_q;
  assign s_axi_bresp            = b_resp_q;
  assign s_axi_arready          = ar_rdy_q;
  assign s_axi_rvalid           = r_valid_q;
  assign s_axi_rdata            = r_data_q;
  assign s_axi_rresp            = r_resp_q;
  assign power_on_reset_event   = por_q;
  assign pulse_code_clock       = pc_clk_q;
  assign pulse_density_clock    = pd_clk_q;
  assign pulse_density_clock_oe = pd_oe_q;
  assign rate_converter_clock   = rc_clk_q;
  assign converter_ctrl         = conv_q;

endmodule

// file: verification/prc_chk_assertions.sv
// port checker for the power, reset and clock register bank
`timescale 1ns/1ps
module prc_chk (
  input wire logic                     clk_sys,
  input wire logic                     rst_n,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_arready,
  input wire logic                     s_axi_rvalid,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic                     memory_regulator_on,
  input wire logic                     fast_oscillator_running,
  input wire logic                     device_active,
  input wire prc_pkg::analog_status_s  analog_status,
  input wire prc_pkg::converter_ctrl_s converter_ctrl
);
  // inputs pass two sync stages, so skip the first cycles after reset
  logic [2:0] up_q;
  always_ff @(posedge clk_sys) up_q <= !rst_n ? 3'h0 : up_q + {2'h0, up_q != 3'h7};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_write_answer: assert property (s_axi_awready |=> s_axi_bvalid) else $error("no write answer");
  a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0) else $error("upper bits");
  a_boost_msb: assert property (up_q == 3'h7 && $past(memory_regulator_on, 3)
    |-> converter_ctrl.boosted_level_select[2]) else $error("boosted msb clear");
  a_slow_trigger: assert property (up_q == 3'h7 && !$past(fast_oscillator_running, 3)
    |-> converter_ctrl.idle_use_slow_clock) else $error("fast trigger");
  a_buck_cause: assert property (converter_ctrl.buck_start
    |-> $past(device_active, 3) && !$past(analog_status.low_rail_present, 3)) else $error("buck start");
  a_boost_cause: assert property (converter_ctrl.boost_permitted
    |-> $past(analog_status.low_rail_above_threshold, 3) || converter_ctrl.low_rail_threshold == 3'h7)
    else $error("boost permitted");
endmodule
bind prc_reg_bank prc_chk chk (.clk_sys, .rst_n, .s_axi_awready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .memory_regulator_on, .fast_oscillator_running, .device_active, .analog_status, .converter_ctrl);

// file: verification/tb_top.sv
// self-checking bench for the power, reset and clock register bank
`timescale 1ns/1ps
module tb_top;
  logic                     clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic                     s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reset_pad, b;
  logic                     slow_xtal_clock, memory_regulator_on, fast_oscillator_running, device_active;
  logic                     power_on_reset_event, pulse_code_clock, pulse_density_clock, pulse_density_clock_oe;
  logic                     rate_converter_clock, slow_rc_clock;
  logic [1:0]               s_axi_bresp, s_axi_rresp;
  logic [2:0]               rc_q = 3'h0;
  logic [3:0]               s_axi_wstrb;
  logic [31:0]              s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, port_pins, r;
  prc_pkg::analog_status_s  analog_status;
  prc_pkg::converter_ctrl_s converter_ctrl;
  int                       miscompares = 0, n_checks = 0, k;
  prc_reg_bank #(.PERIODS_PER_STEP(4)) DUT (.*);
  // slow clock at one eighth of the system rate keeps the hold timer short
  always @(posedge clk_sys) rc_q <= rc_q + 3'h1;
  assign slow_rc_clock = rc_q[2];
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task wt(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task chk(string n, logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(logic [31:0] i, w);
    s_axi_awaddr <= i << 2;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
    r = s_axi_bresp;
  endtask
  task rc(logic [31:0] i, e);
    s_axi_araddr <= i << 2;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
    chk("rdata", s_axi_rdata, e);
  endtask
  task t_regs();
    rc(prc_pkg::IDX_HOLD, 32'h18);
    rc(prc_pkg::IDX_CONV2, 32'h8C20);
    wr(prc_pkg::IDX_STATUS, 32'hFFFF);
    rc(prc_pkg::IDX_STATUS, 32'h244);
    wr(prc_pkg::IDX_CONV1, 32'hFFFFFFFF);
    rc(prc_pkg::IDX_CONV1, 32'hFFEE);
    wr(32'h40, 32'h1);
    chk("bresp", r, 32'h2);
    $display("register test done");
  endtask
  task t_por();
    wr(prc_pkg::IDX_HOLD, 32'h1);
    wr(prc_pkg::IDX_PIN, 32'h81);
    port_pins <= 32'h1;
    wt(12);
    chk("por early", power_on_reset_event, 32'h0);
    wt(40);
    chk("por high", power_on_reset_event, 32'h1);
    port_pins <= 32'h0;
    wt(6);
    chk("por released", power_on_reset_event, 32'h0);
    wr(prc_pkg::IDX_PIN, 32'h1);
    wt(52);
    chk("por active low", power_on_reset_event, 32'h1);
    wr(prc_pkg::IDX_PIN, 32'h0);
    wt(6);
    chk("por disabled", power_on_reset_event, 32'h0);
    $display("reset pin test done");
  endtask
  task t_div();
    wr(prc_pkg::IDX_PDDIV, 32'h302);
    wt(4);
    chk("clock oe", pulse_density_clock_oe, 32'h1);
    k = 0;
    repeat (40) begin
      b = pulse_density_clock;
      wt(1);
      k += (pulse_density_clock !== b);
    end
    chk("toggles", k, 32'h14);
    wr(prc_pkg::IDX_PDDIV, 32'h102);
    wt(4);
    chk("clock oe", pulse_density_clock_oe, 32'h0);
    wr(prc_pkg::IDX_PCDIV, 32'h1001);
    wr(prc_pkg::IDX_RCDIV, 32'h101);
    wr(prc_pkg::IDX_CONV2, 32'h8D21);
    repeat (10) begin
      {b, r[0]} = {rate_converter_clock, pulse_code_clock};
      wt(1);
      k += (rate_converter_clock !== b) + (pulse_code_clock !== r[0]);
    end
    chk("clocks", k, 32'h28);
    chk("cal", converter_ctrl.auto_calibration, 32'h1);
    $display("divider test done");
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, reset_pad, slow_xtal_clock, fast_oscillator_running} = '0;
    {s_axi_bready, s_axi_rready, memory_regulator_on, device_active} = '1;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, port_pins} = '0;
    s_axi_wstrb = 4'hF;
    analog_status = 8'hA4;
    wt(6);
    rst_n <= 1'b1;
    wt(2);
    t_regs();
    t_por();
    t_div();
    complete_run();
  end
  initial begin
    #2000000;
    miscompares++;
    complete_run();
  end
endmodule
